//--- pkg/rerc_map.vh
// Functional notes
// - Converter follows its own enable pin
// - Wait 170 us before switching starts
// - Soft-start ramp 750 us, shortened if precharged
// - Precharged output is never discharged during ramp
// - Discharge off after reset, per-converter enable
// - Discharge load applied while converter disabled
// - Fault below 10 percent, clear past hysteresis
// - Five fault flags readable, alert on fault
// - Comparator disabled while rail reads good
// - Shared linear enable, software disable per regulator
// - Shutdown on undervoltage or overtemperature
// - Undervoltage lockout disables all regulators
// - Memory default select: 1.8 V or 3.3 V
// - Core default select: 1.2 V or 1.6 V
// - Warm reset restores core default, raises reset
// - Warm reset input debounced internally
// - Reset low at power-up, backup rail low
// - Reset driven low on warm reset
// - Reset hold is a configurable delay count
// - Full duty mode near dropout
// - Debounce needs 30 ms steady assertion
// - Hold delay starts when backup rail good
// - Status read releases alert, bits keep fault
`ifndef RERC_MAP_VH
`define RERC_MAP_VH
`define RERC_CLK_MHZ        125
`define RERC_BIAS_US        170
`define RERC_RAMP_US        750
`define RERC_DEBOUNCE_MS    30
`define RERC_HOLD_MS        100
`define RERC_BIAS_CYC       (`RERC_BIAS_US * `RERC_CLK_MHZ)
`define RERC_RAMP_CYC       (`RERC_RAMP_US * `RERC_CLK_MHZ)
`define RERC_DEBOUNCE_CYC   (`RERC_DEBOUNCE_MS * 1000 * `RERC_CLK_MHZ)
`define RERC_HOLD_CYC       (`RERC_HOLD_MS * 1000 * `RERC_CLK_MHZ)
`define RERC_ADDR_STATUS    8'h00
`define RERC_ADDR_DISCH     8'h04
`define RERC_ADDR_LINCTL    8'h08
`define RERC_ADDR_VSEL      8'h0c
`define RERC_ADDR_RUN       8'h10
`define RERC_DISCH_RST      3'h0
`define RERC_LINCTL_RST     2'h3
`define RERC_CORE_DEF_LO    8'h0c
`define RERC_CORE_DEF_HI    8'h10
`endif

//--- hdl/rerc_regulator_control.v
`timescale 1ns/1ps
`default_nettype none
`include "rerc_map.vh"
module rerc_regulator_control #(
    parameter BIAS_CYC     = `RERC_BIAS_CYC,
    parameter RAMP_CYC     = `RERC_RAMP_CYC,
    parameter DEBOUNCE_CYC = `RERC_DEBOUNCE_CYC,
    parameter HOLD_CYC     = `RERC_HOLD_CYC
) (
    input  wire        core_clk_i,
    input  wire        resetn_i,
    input  wire        clk_en_i,
    input  wire [2:0]  converter_enable_pin_i,
    input  wire        linear_regulators_enable_pin_i,
    input  wire        core_default_select_pin_i,
    input  wire        memory_default_select_pin_i,
    input  wire        warm_reset_input_i,
    input  wire        backup_rail_low_i,
    input  wire        backup_rail_good_i,
    input  wire        supply_undervoltage_lock_i,
    input  wire        thermal_shutdown_i,
    input  wire [4:0]  rail_below_fault_i,
    input  wire [4:0]  rail_above_recover_i,
    input  wire [2:0]  output_precharged_i,
    input  wire [2:0]  near_dropout_i,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    output reg  [2:0]  converter_on_o,
    output reg  [2:0]  switching_o,
    output reg  [2:0]  full_duty_o,
    output reg  [2:0]  discharge_load_o,
    output reg  [1:0]  linear_on_o,
    output reg  [4:0]  comparator_enable_o,
    output reg         core_default_hi_o,
    output reg         memory_default_hi_o,
    output reg         core_vsel_restore_o,
    output wire        alert_o,
    output wire        alert_oe_o,
    output wire        system_reset_o,
    output wire        system_reset_oe_o
);
    localparam ST_OFF  = 2'd0;
    localparam ST_BIAS = 2'd1;
    localparam ST_RAMP = 2'd2;
    localparam ST_RUN  = 2'd3;

    // Two-flop synchronisers for every pin-level input
    // Bit positions of each pin group inside the synchroniser word
    localparam P_PRE   = 0;
    localparam P_ABOVE = 3;
    localparam P_BELOW = 8;
    localparam P_OT    = 13;
    localparam P_SUPPLY_UNDERVOLTAGE_LOCK  = 14;
    localparam P_GOOD  = 15;
    localparam P_LOW   = 16;
    localparam P_WARM  = 17;
    localparam P_MSEL  = 18;
    localparam P_CSEL  = 19;
    localparam P_LIN   = 20;
    localparam P_EN    = 21;
    localparam SW      = 24;
    wire [SW-1:0] raw_in = {converter_enable_pin_i,
        linear_regulators_enable_pin_i, core_default_select_pin_i,
        memory_default_select_pin_i, warm_reset_input_i,
        backup_rail_low_i, backup_rail_good_i,
        supply_undervoltage_lock_i, thermal_shutdown_i,
        rail_below_fault_i, rail_above_recover_i, output_precharged_i};
    reg [SW-1:0] sync1_reg;
    reg [SW-1:0] sync2_reg;
    reg [2:0]    dropout1_reg;
    reg [2:0]    dropout2_reg;
    always @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            sync1_reg    <= {SW{1'b0}};
            sync2_reg    <= {SW{1'b0}};
            dropout1_reg <= 3'h0;
            dropout2_reg <= 3'h0;
        end
        else if (clk_en_i)
        begin
            sync1_reg    <= raw_in;
            sync2_reg    <= sync1_reg;
            dropout1_reg <= near_dropout_i;
            dropout2_reg <= dropout1_reg;
        end
    end
    wire [2:0] en_s      = sync2_reg[P_EN+2:P_EN];
    wire       lin_en_s  = sync2_reg[P_LIN];
    wire       core_sel  = sync2_reg[P_CSEL];
    wire       mem_sel   = sync2_reg[P_MSEL];
    wire       warm_s    = sync2_reg[P_WARM];
    wire       bk_low_s  = sync2_reg[P_LOW];
    wire       bk_good_s = sync2_reg[P_GOOD];
    wire       supply_undervoltage_lock_s    = sync2_reg[P_SUPPLY_UNDERVOLTAGE_LOCK];
    wire       ot_s      = sync2_reg[P_OT];
    wire [4:0] below_s   = sync2_reg[P_BELOW+4:P_BELOW];
    wire [4:0] above_s   = sync2_reg[P_ABOVE+4:P_ABOVE];
    wire [2:0] pre_s     = sync2_reg[P_PRE+2:P_PRE];
    wire       shutdown  = supply_undervoltage_lock_s | ot_s;

    // Registers
    reg [2:0] disch_reg;
    reg [1:0] linctl_reg;
    reg [4:0] fault_reg;
    reg       alert_rel_reg;
    wire      rd_status;

    // Converter sequencing
    reg [1:0]  conv_st_reg [0:2];
    reg [31:0] conv_cnt_reg [0:2];
    wire [4:0] rail_ready;

    // Converter switches while ramping and once running
    function st_live;
        input [1:0] st;
        begin
            st_live = (st == ST_RAMP) || (st == ST_RUN);
        end
    endfunction
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : g_conv
            wire on_req = en_s[g] & ~shutdown;
            always @(posedge core_clk_i or negedge resetn_i)
            begin
                if (!resetn_i)
                begin
                    conv_st_reg[g]  <= ST_OFF;
                    conv_cnt_reg[g] <= 32'h0;
                end
                else if (clk_en_i)
                begin
                    if (!on_req)
                    begin
                        conv_st_reg[g]  <= ST_OFF;
                        conv_cnt_reg[g] <= 32'h0;
                    end
                    else
                    begin
                        case (conv_st_reg[g])
                        ST_OFF:
                        begin
                            conv_st_reg[g]  <= ST_BIAS;
                            conv_cnt_reg[g] <= 32'h0;
                        end
                        ST_BIAS:
                        begin
                            if (conv_cnt_reg[g] >= BIAS_CYC - 1)
                            begin
                                conv_st_reg[g]  <= ST_RAMP;
                                // Precharged output starts partway up
                                conv_cnt_reg[g] <= pre_s[g] ?
                                    RAMP_CYC / 2 : 32'h0;
                            end
                            else
                                conv_cnt_reg[g] <= conv_cnt_reg[g] + 32'h1;
                        end
                        ST_RAMP:
                        begin
                            if (conv_cnt_reg[g] >= RAMP_CYC - 1)
                                conv_st_reg[g] <= ST_RUN;
                            else
                                conv_cnt_reg[g] <= conv_cnt_reg[g] + 32'h1;
                        end
                        ST_RUN:
                            conv_st_reg[g] <= ST_RUN;
                        default:
                            conv_st_reg[g] <= ST_OFF;
                        endcase
                    end
                end
            end
            always @(posedge core_clk_i or negedge resetn_i)
            begin
                if (!resetn_i)
                begin
                    converter_on_o[g]   <= 1'b0;
                    switching_o[g]      <= 1'b0;
                    full_duty_o[g]      <= 1'b0;
                    discharge_load_o[g] <= 1'b0;
                end
                else if (clk_en_i)
                begin
                    converter_on_o[g] <= on_req;
                    switching_o[g] <= on_req && st_live(conv_st_reg[g]);
                    full_duty_o[g] <= on_req &&
                        conv_st_reg[g] == ST_RUN && dropout2_reg[g];
                    // Load only while disabled, so a precharged ramp is safe
                    discharge_load_o[g] <= disch_reg[g] & ~on_req;
                end
            end
            assign rail_ready[g] = (conv_st_reg[g] == ST_RUN);
        end
    endgenerate

    // Linear regulators: shared pin gated by software control bits
    reg [1:0]  lin_ramped_reg;
    always @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            linear_on_o    <= 2'h0;
            lin_ramped_reg <= 2'h0;
        end
        else if (clk_en_i)
        begin
            linear_on_o <= {2{lin_en_s & ~shutdown}} & linctl_reg;
            lin_ramped_reg <= linear_on_o;
        end
    end
    assign rail_ready[4:3] = linear_on_o & lin_ramped_reg;

    // Fault flags with hysteresis; set beats the read release
    integer i;
    always @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            fault_reg           <= 5'h0;
            comparator_enable_o <= 5'h0;
            alert_rel_reg       <= 1'b0;
        end
        else if (clk_en_i)
        begin
            for (i = 0; i < 5; i = i + 1)
            begin
                // Comparator watches only a rail flagged as faulty
                comparator_enable_o[i] <= fault_reg[i];
                if (!rail_ready[i])
                    fault_reg[i] <= 1'b0;
                else if (below_s[i])
                    fault_reg[i] <= 1'b1;
                else if (fault_reg[i] && above_s[i])
                    fault_reg[i] <= 1'b0;
            end
            if (|(rail_ready & below_s & ~fault_reg))
                alert_rel_reg <= 1'b0;
            else if (rd_status)
                alert_rel_reg <= 1'b1;
        end
    end
    assign alert_o    = 1'b0;
    assign alert_oe_o = (|fault_reg) & ~alert_rel_reg;

    // Warm reset debounce and system reset hold
    reg [31:0] deb_cnt_reg;
    reg        warm_ok_reg;
    reg [31:0] hold_cnt_reg;
    reg        rst_low_reg;
    always @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            deb_cnt_reg  <= 32'h0;
            warm_ok_reg  <= 1'b0;
            hold_cnt_reg <= 32'h0;
            rst_low_reg  <= 1'b1;
        end
        else if (clk_en_i)
        begin
            // A bounce restarts the filter from zero
            if (!warm_s)
            begin
                deb_cnt_reg <= 32'h0;
                warm_ok_reg <= 1'b0;
            end
            else if (deb_cnt_reg >= DEBOUNCE_CYC - 1)
                warm_ok_reg <= 1'b1;
            else
                deb_cnt_reg <= deb_cnt_reg + 32'h1;
            if (bk_low_s || warm_ok_reg || !bk_good_s)
            begin
                rst_low_reg  <= 1'b1;
                hold_cnt_reg <= 32'h0;
            end
            else if (hold_cnt_reg >= HOLD_CYC - 1)
                rst_low_reg <= 1'b0;
            else
                hold_cnt_reg <= hold_cnt_reg + 32'h1;
        end
    end
    assign system_reset_o    = 1'b0;
    assign system_reset_oe_o = rst_low_reg;

    // Default selects and core restore
    always @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            core_default_hi_o   <= 1'b0;
            memory_default_hi_o <= 1'b0;
            core_vsel_restore_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            core_default_hi_o   <= core_sel;
            memory_default_hi_o <= mem_sel;
            core_vsel_restore_o <= warm_ok_reg | supply_undervoltage_lock_s | rst_low_reg;
        end
    end

    // AHB-Lite slave, zero wait states, always OKAY
    reg        ph_wr_reg;
    reg        ph_rd_reg;
    reg [7:0]  ph_addr_reg;
    reg [7:0]  core_vsel_reg;
    wire       take = hsel & htrans[1] & hready;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign rd_status = take & ~hwrite & (haddr[7:0] == `RERC_ADDR_STATUS);

    // Data-phase write strobe for one register offset
    function wr_hit;
        input       wr;
        input [7:0] cur;
        input [7:0] addr;
        begin
            wr_hit = wr && (cur == addr);
        end
    endfunction
    always @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ph_wr_reg     <= 1'b0;
            ph_rd_reg     <= 1'b0;
            ph_addr_reg   <= 8'h00;
            hrdata        <= 32'h0;
            disch_reg     <= `RERC_DISCH_RST;
            linctl_reg    <= `RERC_LINCTL_RST;
            core_vsel_reg <= `RERC_CORE_DEF_LO;
        end
        else if (clk_en_i)
        begin
            ph_wr_reg   <= take & hwrite;
            ph_rd_reg   <= take & ~hwrite;
            ph_addr_reg <= haddr[7:0];
            if (take && !hwrite)
            begin
                case (haddr[7:0])
                `RERC_ADDR_STATUS: hrdata <= {27'h0, fault_reg};
                `RERC_ADDR_DISCH:  hrdata <= {29'h0, disch_reg};
                `RERC_ADDR_LINCTL: hrdata <= {30'h0, linctl_reg};
                `RERC_ADDR_VSEL:   hrdata <= {24'h0, core_vsel_reg};
                `RERC_ADDR_RUN:    hrdata <= {27'h0, rail_ready};
                default:           hrdata <= 32'h0;
                endcase
            end
            // Restore outranks a software write in the same cycle
            if (core_vsel_restore_o)
                core_vsel_reg <= core_default_hi_o ? `RERC_CORE_DEF_HI :
                    `RERC_CORE_DEF_LO;
            else if (wr_hit(ph_wr_reg, ph_addr_reg, `RERC_ADDR_VSEL))
                core_vsel_reg <= hwdata[7:0];
            if (wr_hit(ph_wr_reg, ph_addr_reg, `RERC_ADDR_DISCH))
                disch_reg <= hwdata[2:0];
            if (wr_hit(ph_wr_reg, ph_addr_reg, `RERC_ADDR_LINCTL))
                linctl_reg <= hwdata[1:0];
        end
    end
endmodule
`default_nettype wire

//--- verification/rerc_rail_model.sv
`timescale 1ns/1ps
`default_nettype none
module rerc_rail_model (
    input  wire logic       core_clk_i,
    input  wire logic [4:0] fault_cmd_i,
    output wire logic [4:0] rail_below_fault_o,
    output wire logic [4:0] rail_above_recover_o
);
    logic [4:0] below_reg = 5'h00;
    logic [4:0] band_reg = 5'h00;
    logic [4:0] above_reg = 5'h00;
    // A recovering rail lingers one cycle inside the hysteresis band,
    // so neither comparator reads true while it climbs back
    always @(posedge core_clk_i)
    begin
        below_reg <= fault_cmd_i;
        band_reg  <= fault_cmd_i;
        above_reg <= ~fault_cmd_i & ~band_reg;
    end
    assign rail_below_fault_o = below_reg;
    assign rail_above_recover_o = above_reg;
endmodule
`default_nettype wire

//--- verification/rerc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rerc_monitor #(
    parameter DEBOUNCE_CYC = 6
) (
    input wire logic       core_clk_i,
    input wire logic       resetn_i,
    input wire logic [2:0] converter_enable_pin_i,
    input wire logic       core_default_select_pin_i,
    input wire logic       warm_reset_input_i,
    input wire logic       backup_rail_low_i,
    input wire logic       supply_undervoltage_lock_i,
    input wire logic       thermal_shutdown_i,
    input wire logic [2:0] converter_on_o,
    input wire logic [2:0] switching_o,
    input wire logic [2:0] discharge_load_o,
    input wire logic       core_default_hi_o,
    input wire logic       core_vsel_restore_o,
    input wire logic       alert_o,
    input wire logic       system_reset_o,
    input wire logic       system_reset_oe_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    logic [7:0] warm_cnt_reg;
    // Margin of six cycles covers input sync and the reset register
    always_ff @(posedge core_clk_i or negedge resetn_i)
        if (!resetn_i)
            warm_cnt_reg <= 8'h00;
        else if (!warm_reset_input_i)
            warm_cnt_reg <= 8'h00;
        else if (warm_cnt_reg != 8'hff)
            warm_cnt_reg <= warm_cnt_reg + 8'h01;
    sequence s_supply_undervoltage_lock_held;
        supply_undervoltage_lock_i [*6];
    endsequence
    sequence s_heat_held;
        thermal_shutdown_i [*6];
    endsequence
    sequence s_pin_steady;
        $stable(core_default_select_pin_i) [*5];
    endsequence
    a_backup_hold: assert property (backup_rail_low_i [*4] |->
        system_reset_oe_o)
        else $error("reset released with backup rail low");
    a_warm_accept: assert property (
        warm_cnt_reg == DEBOUNCE_CYC + 6 |->
        system_reset_oe_o && core_vsel_restore_o)
        else $error("held warm reset not acted on");
    a_supply_undervoltage_lock_off: assert property (s_supply_undervoltage_lock_held |->
        converter_on_o == 3'h0 && switching_o == 3'h0)
        else $error("converter running under lockout");
    a_heat_off: assert property (s_heat_held |->
        converter_on_o == 3'h0 && switching_o == 3'h0)
        else $error("converter running while overheated");
    a_pin_follow: assert property (!converter_enable_pin_i[1] [*5] |->
        !converter_on_o[1])
        else $error("converter on with its pin low");
    a_bias_wait: assert property ($rose(switching_o[0]) |->
        $past(converter_on_o[0], 3))
        else $error("switching began before bias delay");
    a_disch_idle: assert property (
        (discharge_load_o & (converter_on_o | switching_o)) == 3'h0)
        else $error("discharge load on a live converter");
    a_core_default: assert property (s_pin_steady |->
        core_default_hi_o == core_default_select_pin_i)
        else $error("core default does not follow its pin");
    a_open_drain: assert property (!alert_o && !system_reset_o)
        else $error("open-drain output driven high");
endmodule
bind rerc_regulator_control rerc_monitor #(.DEBOUNCE_CYC(DEBOUNCE_CYC))
    u_mon (.*);
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "rerc_map.vh"
module tb;
    logic        core_clk_i = 0, resetn_i = 0, clk_en_i = 1;
    logic [2:0]  converter_enable_pin_i = 0;
    logic        linear_regulators_enable_pin_i = 0;
    logic        core_default_select_pin_i = 0;
    logic        memory_default_select_pin_i = 0;
    logic        warm_reset_input_i = 0;
    logic        backup_rail_low_i = 1, backup_rail_good_i = 0;
    logic        supply_undervoltage_lock_i = 0, thermal_shutdown_i = 0;
    logic [2:0]  output_precharged_i = 0, near_dropout_i = 0;
    logic        hsel = 0, hwrite = 0;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 0, hwdata = 0;
    logic [4:0]  fault_cmd = 0;
    wire  [4:0]  rail_below_fault_i, rail_above_recover_i, comparator_enable_o;
    wire         hready, hreadyout, hresp, core_default_hi_o;
    wire         memory_default_hi_o, core_vsel_restore_o, alert_o;
    wire         alert_oe_o, system_reset_o, system_reset_oe_o;
    wire  [31:0] hrdata;
    wire  [2:0]  converter_on_o, switching_o, full_duty_o, discharge_load_o;
    wire  [1:0]  linear_on_o;
    int          err_count = 0, check_count = 0, cyc = 0;
    assign hready = hreadyout;
    // Short counts keep the run brief; expectations use these values
    rerc_regulator_control #(.BIAS_CYC(4), .RAMP_CYC(8), .DEBOUNCE_CYC(6),
        .HOLD_CYC(10)) dut (.*);
    rerc_rail_model u_rail (.core_clk_i(core_clk_i), .fault_cmd_i(fault_cmd),
        .rail_below_fault_o(rail_below_fault_i),
        .rail_above_recover_o(rail_above_recover_i));
    initial
    begin
        forever #4 core_clk_i = ~core_clk_i;
    end
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge core_clk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_count++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        do @(posedge core_clk_i); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge core_clk_i); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] x);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        check(r, x);
    endtask
    function automatic logic [2:0] f_disch(input logic [2:0] d, en);
        return d & ~en;
    endfunction
    function automatic logic [31:0] f_core_def(input logic pin);
        return pin ? `RERC_CORE_DEF_HI : `RERC_CORE_DEF_LO;
    endfunction
    initial
    begin
        logic [31:0] r;
        logic [2:0]  d, e;
        int          k;
        void'($urandom(30308));
        core_default_select_pin_i <= 1'($urandom);
        memory_default_select_pin_i <= 1'($urandom);
        wait_cyc(8);
        resetn_i <= 1'b1;
        wait_cyc(6);
        check(system_reset_oe_o, 1);
        check(core_default_hi_o, core_default_select_pin_i);
        check(memory_default_hi_o, memory_default_select_pin_i);
        backup_rail_low_i <= 1'b0;
        backup_rail_good_i <= 1'b1;
        wait_cyc(8);
        check(system_reset_oe_o, 1);
        wait_cyc(12);
        check(system_reset_oe_o, 0);
        rd_chk(`RERC_ADDR_DISCH, `RERC_DISCH_RST);
        rd_chk(`RERC_ADDR_LINCTL, `RERC_LINCTL_RST);
        rd_chk(`RERC_ADDR_VSEL, f_core_def(core_default_select_pin_i));
        rd_chk(32'h20, 0);
        output_precharged_i <= 3'($urandom);
        near_dropout_i <= 3'($urandom);
        converter_enable_pin_i <= 3'h7;
        linear_regulators_enable_pin_i <= 1'b1;
        wait_cyc(12);
        // Precharged outputs start their ramp halfway up and finish first
        rd_chk(`RERC_ADDR_RUN, {27'h0, 2'h3, output_precharged_i});
        wait_cyc(16);
        check(switching_o, 3'h7);
        check(full_duty_o, near_dropout_i);
        check(linear_on_o, 2'h3);
        check(alert_oe_o, 0);
        rd_chk(`RERC_ADDR_STATUS, 0);
        for (k = 0; k < 5; k++)
        begin
            fault_cmd <= 5'h01 << k;
            wait_cyc(8);
            check(alert_oe_o, 1);
            check(comparator_enable_o, 5'h01 << k);
            rd_chk(`RERC_ADDR_STATUS, 5'h01 << k);
            wait_cyc(2);
            check(alert_oe_o, 0);
            rd_chk(`RERC_ADDR_STATUS, 5'h01 << k);
            fault_cmd <= 5'h00;
            wait_cyc(8);
            rd_chk(`RERC_ADDR_STATUS, 0);
            check(comparator_enable_o, 0);
        end
        d = 3'($urandom);
        bus(1'b1, `RERC_ADDR_DISCH, {29'h0, d}, r);
        rd_chk(`RERC_ADDR_DISCH, {29'h0, d});
        for (k = 0; k < 2; k++)
        begin
            e = k ? 3'h0 : 3'($urandom);
            converter_enable_pin_i <= e;
            wait_cyc(8);
            check(discharge_load_o, f_disch(d, e));
        end
        bus(1'b1, `RERC_ADDR_LINCTL, 32'h1, r);
        wait_cyc(4);
        check(linear_on_o, 2'h1);
        bus(1'b1, `RERC_ADDR_LINCTL, 32'h3, r);
        converter_enable_pin_i <= 3'h7;
        wait_cyc(30);
        // Clock enable low: a pin change must not reach the converters
        clk_en_i <= 1'b0;
        converter_enable_pin_i <= 3'h0;
        wait_cyc(4);
        check(converter_on_o, 3'h7);
        clk_en_i <= 1'b1;
        converter_enable_pin_i <= 3'h7;
        for (k = 0; k < 2; k++)
        begin
            supply_undervoltage_lock_i <= (k == 0);
            thermal_shutdown_i <= (k == 1);
            wait_cyc(8);
            check(converter_on_o, 0);
            check(linear_on_o, 0);
            check(discharge_load_o, f_disch(d, 3'h0));
            supply_undervoltage_lock_i <= 1'b0;
            thermal_shutdown_i <= 1'b0;
            wait_cyc(30);
            check(switching_o, 3'h7);
        end
        bus(1'b1, `RERC_ADDR_VSEL, 32'h5, r);
        warm_reset_input_i <= 1'b1;
        wait_cyc(3);
        warm_reset_input_i <= 1'b0;
        wait_cyc(10);
        check(system_reset_oe_o, 0);
        warm_reset_input_i <= 1'b1;
        wait_cyc(14);
        check(system_reset_oe_o, 1);
        check(switching_o, 3'h7);
        warm_reset_input_i <= 1'b0;
        rd_chk(`RERC_ADDR_VSEL, f_core_def(core_default_select_pin_i));
        rd_chk(`RERC_ADDR_DISCH, {29'h0, d});
        wait_cyc(30);
        check(system_reset_oe_o, 0);
        complete_run();
    end
endmodule
`default_nettype wire
